// File: logic/dio_pkg.sv
`default_nettype none
package dio_pkg;
    // Port structure
    localparam int NPORT = 6;
    localparam int NIRQ = 2;

    // Register addresses, one byte each
    localparam logic [7:0] IN_ADDR [NPORT] = '{8'h20, 8'h28, 8'h18, 8'h1C, 8'h30, 8'h34};
    localparam logic [7:0] OUT_ADDR [NPORT] = '{8'h21, 8'h29, 8'h19, 8'h1D, 8'h31, 8'h35};
    localparam logic [7:0] DIR_ADDR [NPORT] = '{8'h22, 8'h2A, 8'h1A, 8'h1E, 8'h32, 8'h36};
    localparam logic [7:0] SEL_ADDR [NPORT] = '{8'h26, 8'h2E, 8'h1B, 8'h1F, 8'h33, 8'h37};
    localparam logic [7:0] IFG_ADDR [NIRQ] = '{8'h23, 8'h2B};
    localparam logic [7:0] IES_ADDR [NIRQ] = '{8'h24, 8'h2C};
    localparam logic [7:0] IE_ADDR [NIRQ] = '{8'h25, 8'h2D};
    localparam logic [7:0] STAT_ADDR = 8'h38;
    localparam logic [7:0] MASK_ADDR = 8'h39;

    // Status bit positions
    localparam int STAT_FIRST_BIT = 0;
    localparam int STAT_SECOND_BIT = 1;

    // Per-port configuration and interrupt state
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] dir;
        logic [7:0] sel;
    } dio_cfg_t;

    typedef struct packed {
        logic [7:0] ifg;
        logic [7:0] ies;
        logic [7:0] ie;
    } dio_irq_t;

    // Reset values
    localparam dio_cfg_t CFG_RST = 24'h00_0000;
    localparam dio_irq_t IRQ_RST = 24'h00_0000;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Timing: shortest pin event, in nanoseconds, and its cycle count
    localparam real CLK_PERIOD_NS = 4.0;
    localparam real EVT_MIN_NS = 1.5 * CLK_PERIOD_NS;
    localparam int EVT_MIN_CYC = int'($ceil(EVT_MIN_NS / CLK_PERIOD_NS));
endpackage
`default_nettype wire

// File: logic/dio_ports.sv
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module dio_ports
    import dio_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata_q,
    // Processor state
    input wire logic global_interrupt_enable,
    // Pins
    input wire logic [NPORT-1:0][7:0] pin_in,
    output logic [NPORT-1:0][7:0] pin_out_q,
    output logic [NPORT-1:0][7:0] pin_oe_q,
    // Peripheral side
    input wire logic [NPORT-1:0][7:0] periph_out,
    output logic [NPORT-1:0][7:0] periph_in_q,
    // Interrupts
    output logic [NIRQ-1:0] port_irq_q,
    output logic irq_q
);

    dio_cfg_t cfg_q [NPORT];
    dio_irq_t pirq_q [NIRQ];
    logic [NPORT-1:0][7:0] sync1_q;
    logic [NPORT-1:0][7:0] sync2_q;
    logic [NIRQ-1:0][7:0] trig;
    logic [NIRQ-1:0][7:0] trig_prev_q;
    logic [NIRQ-1:0][7:0] edge_set;
    logic [NIRQ-1:0] req;
    logic [7:0] stat_q;
    logic [7:0] mask_q;
    logic [7:0] stat_set;
    logic [7:0] rdata_d;

    // Two-stage synchroniser; only the second stage feeds logic
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
        end
    end

    // Configuration registers of all six ports
    always_ff @(posedge clock) begin
        for (int p = 0; p < NPORT; p++) begin
            if (!rstn) begin
                cfg_q[p] <= CFG_RST;
            end else if (wr_en) begin
                if (addr == OUT_ADDR[p]) begin
                    cfg_q[p].out <= wdata;
                end
                if (addr == DIR_ADDR[p]) begin
                    cfg_q[p].dir <= wdata;
                end
                if (addr == SEL_ADDR[p]) begin
                    cfg_q[p].sel <= wdata;
                end
            end
        end
    end

    // Pin drive: mux by select, enable from direction regardless of function
    always_ff @(posedge clock) begin
        for (int p = 0; p < NPORT; p++) begin
            if (!rstn) begin
                pin_out_q[p] <= 8'h00;
                pin_oe_q[p] <= 8'h00;
            end else begin
                pin_out_q[p] <= (cfg_q[p].sel & periph_out[p])
                    | (~cfg_q[p].sel & cfg_q[p].out);
                pin_oe_q[p] <= cfg_q[p].dir;
            end
        end
    end

    // Peripheral input latch; holds last level once deselected
    always_ff @(posedge clock) begin
        for (int p = 0; p < NPORT; p++) begin
            if (!rstn) begin
                periph_in_q[p] <= 8'h00;
            end else begin
                periph_in_q[p] <= (cfg_q[p].sel & sync2_q[p])
                    | (~cfg_q[p].sel & periph_in_q[p]);
            end
        end
    end

    // Edge sense: xor with edge select, so an edge-select change that
    // raises the sensed level also counts as an edge
    always_comb begin
        for (int q = 0; q < NIRQ; q++) begin
            trig[q] = sync2_q[q] ^ pirq_q[q].ies;
            edge_set[q] = trig[q] & ~trig_prev_q[q] & ~cfg_q[q].sel;
        end
    end

    // Previous sensed level; pin edges caused by own output or direction
    // writes come back through the pin and are caught the same way
    always_ff @(posedge clock) begin
        if (!rstn) begin
            trig_prev_q <= '0;
        end else begin
            trig_prev_q <= trig;
        end
    end

    // Interrupt registers of the two interrupt-capable ports
    always_ff @(posedge clock) begin
        for (int q = 0; q < NIRQ; q++) begin
            if (!rstn) begin
                pirq_q[q] <= IRQ_RST;
            end else begin
                if (wr_en && addr == IFG_ADDR[q]) begin
                    pirq_q[q].ifg <= wdata | edge_set[q];
                end else begin
                    pirq_q[q].ifg <= pirq_q[q].ifg | edge_set[q];
                end
                if (wr_en && addr == IES_ADDR[q]) begin
                    pirq_q[q].ies <= wdata;
                end
                if (wr_en && addr == IE_ADDR[q]) begin
                    pirq_q[q].ie <= wdata;
                end
            end
        end
    end

    // Level request per port while any enabled flag of an unselected pin stays set and the global enable is on
    always_comb begin
        for (int q = 0; q < NIRQ; q++) begin
            req[q] = (|(pirq_q[q].ifg & pirq_q[q].ie & ~cfg_q[q].sel))
                && global_interrupt_enable;
        end
    end

    // One line per port vector
    always_ff @(posedge clock) begin
        if (!rstn) begin
            port_irq_q <= '0;
        end else begin
            port_irq_q <= req;
        end
    end

    // Sticky status: a port's flag newly set by a pin edge or software
    always_comb begin
        stat_set = 8'h00;
        stat_set[STAT_FIRST_BIT] = |edge_set[0];
        stat_set[STAT_SECOND_BIT] = |edge_set[1];
        if (wr_en && addr == IFG_ADDR[0]) begin
            stat_set[STAT_FIRST_BIT] = stat_set[STAT_FIRST_BIT] | (|wdata);
        end
        if (wr_en && addr == IFG_ADDR[1]) begin
            stat_set[STAT_SECOND_BIT] = stat_set[STAT_SECOND_BIT] | (|wdata);
        end
    end

    // Status clears on read; a new event in the same cycle wins
    always_ff @(posedge clock) begin
        if (!rstn) begin
            stat_q <= STAT_RST;
        end else if (rd_en && addr == STAT_ADDR) begin
            stat_q <= stat_set;
        end else begin
            stat_q <= stat_q | stat_set;
        end
    end

    // Mask register
    always_ff @(posedge clock) begin
        if (!rstn) begin
            mask_q <= MASK_RST;
        end else if (wr_en && addr == MASK_ADDR) begin
            mask_q <= wdata;
        end
    end

    // Summary interrupt, one cycle behind status
    always_ff @(posedge clock) begin
        if (!rstn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(stat_q & mask_q);
        end
    end

    // Read decode; unmapped addresses read zero
    always_comb begin
        rdata_d = 8'h00;
        for (int p = 0; p < NPORT; p++) begin
            if (addr == IN_ADDR[p]) begin
                rdata_d = sync2_q[p];
            end
            if (addr == OUT_ADDR[p]) begin
                rdata_d = cfg_q[p].out;
            end
            if (addr == DIR_ADDR[p]) begin
                rdata_d = cfg_q[p].dir;
            end
            if (addr == SEL_ADDR[p]) begin
                rdata_d = cfg_q[p].sel;
            end
        end
        for (int q = 0; q < NIRQ; q++) begin
            if (addr == IFG_ADDR[q]) begin
                rdata_d = pirq_q[q].ifg;
            end
            if (addr == IES_ADDR[q]) begin
                rdata_d = pirq_q[q].ies;
            end
            if (addr == IE_ADDR[q]) begin
                rdata_d = pirq_q[q].ie;
            end
        end
        if (addr == STAT_ADDR) begin
            rdata_d = stat_q;
        end
        if (addr == MASK_ADDR) begin
            rdata_d = mask_q;
        end
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rdata_q <= RDATA_RST;
        end else if (rd_en) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= RDATA_RST;
        end
    end

    // Checks

    sequence s_dir_write;
        wr_en && addr == DIR_ADDR[0];
    endsequence

    property p_dir_oe;
        @(posedge clock) disable iff (!rstn)
        s_dir_write |-> ##2 pin_oe_q[0] == $past(wdata, 2);
    endproperty
    a_dir_oe: assert property (p_dir_oe) else $error("direction write not on enable");

    property p_io_out;
        @(posedge clock) disable iff (!rstn)
        (wr_en && addr == OUT_ADDR[2] && cfg_q[2].sel == 8'h00)
            ##1 (cfg_q[2].sel == 8'h00) |=> pin_out_q[2] == $past(wdata, 2);
    endproperty
    a_io_out: assert property (p_io_out) else $error("output value not on pin");

    property p_periph_out;
        @(posedge clock) disable iff (!rstn)
        cfg_q[3].sel == 8'hFF |=> pin_out_q[3] == $past(periph_out[3]);
    endproperty
    a_periph_out: assert property (p_periph_out) else $error("peripheral not on pin");

    property p_in_read;
        @(posedge clock) disable iff (!rstn)
        rd_en && addr == IN_ADDR[1] |=> rdata_q == $past(sync2_q[1]);
    endproperty
    a_in_read: assert property (p_in_read) else $error("input read wrong");

    property p_latch_hold;
        @(posedge clock) disable iff (!rstn)
        cfg_q[4].sel == 8'h00 ##1 cfg_q[4].sel == 8'h00 |-> $stable(periph_in_q[4]);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("peripheral latch moved");

    property p_sel_blocks;
        @(posedge clock) disable iff (!rstn)
        !(wr_en && addr == IFG_ADDR[1])
            |=> (pirq_q[1].ifg & ~$past(pirq_q[1].ifg) & $past(cfg_q[1].sel)) == 8'h00;
    endproperty
    a_sel_blocks: assert property (p_sel_blocks) else $error("selected pin set flag");

    property p_edge_sets;
        @(posedge clock) disable iff (!rstn)
        edge_set[1] != 8'h00 |=> (pirq_q[1].ifg & $past(edge_set[1])) == $past(edge_set[1]);
    endproperty
    a_edge_sets: assert property (p_edge_sets) else $error("edge lost");

    property p_no_auto_clear;
        @(posedge clock) disable iff (!rstn)
        !(wr_en && addr == IFG_ADDR[0])
            |=> (pirq_q[0].ifg & $past(pirq_q[0].ifg)) == $past(pirq_q[0].ifg);
    endproperty
    a_no_auto_clear: assert property (p_no_auto_clear) else $error("flag cleared itself");

    property p_sw_set;
        @(posedge clock) disable iff (!rstn)
        wr_en && addr == IFG_ADDR[1] |=> pirq_q[1].ifg == ($past(wdata) | $past(edge_set[1]));
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("flag write wrong");

    property p_request;
        @(posedge clock) disable iff (!rstn)
        port_irq_q[0] |-> $past(global_interrupt_enable)
            && $past(|(pirq_q[0].ifg & pirq_q[0].ie));
    endproperty
    a_request: assert property (p_request) else $error("request without enables");

    property p_held_request;
        @(posedge clock) disable iff (!rstn)
        req[1] && !(wr_en && addr == IFG_ADDR[1]) && !(wr_en && addr == IE_ADDR[1])
            && !(wr_en && addr == SEL_ADDR[1]) && global_interrupt_enable
            |=> port_irq_q[1];
    endproperty
    a_held_request: assert property (p_held_request) else $error("request dropped");

    property p_stat_clear;
        @(posedge clock) disable iff (!rstn)
        rd_en && addr == STAT_ADDR && stat_set == 8'h00 |=> stat_q == 8'h00;
    endproperty
    a_stat_clear: assert property (p_stat_clear) else $error("status not cleared");

endmodule
`default_nettype wire

// File: sim/dio_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module dio_pin_model
    import dio_pkg::*;
(
    // Device drive
    input wire logic [NPORT-1:0][7:0] pin_out_q,
    input wire logic [NPORT-1:0][7:0] pin_oe_q,
    // External drivers on the board
    input wire logic [NPORT-1:0][7:0] ext_val,
    input wire logic [NPORT-1:0][7:0] ext_en,
    // Resolved pin levels
    output logic [NPORT-1:0][7:0] pin_in
);
    // Device wins, then board driver; a released pin falls to its pull-down
    always_comb begin
        pin_in = (pin_out_q & pin_oe_q) | (ext_val & ext_en & ~pin_oe_q);
    end
endmodule
`default_nettype wire

// File: sim/digital_io_ports_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin failures++; \
    $display("FAIL %s exp %h got %h", nm, ex, got); end end
module digital_io_ports_tb
    import dio_pkg::*;
;
    logic clock, rstn, wr_en, rd_en, global_interrupt_enable, irq_q;
    logic [7:0] addr, wdata, rdata_q;
    logic [NPORT-1:0][7:0] pin_in, pin_out_q, pin_oe_q, periph_out, periph_in_q;
    logic [NPORT-1:0][7:0] ext_val, ext_en;
    logic [NIRQ-1:0] port_irq_q;
    int failures = 0;
    int num_checks = 0;
    int cyc = 0;

    // Device and the board around its pins
    dio_ports dut_u (.clock(clock), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata_q(rdata_q), .global_interrupt_enable(global_interrupt_enable),
        .pin_in(pin_in),
        .pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .periph_out(periph_out),
        .periph_in_q(periph_in_q), .port_irq_q(port_irq_q), .irq_q(irq_q));
    dio_pin_model pins_u (.pin_out_q(pin_out_q), .pin_oe_q(pin_oe_q), .ext_val(ext_val),
        .ext_en(ext_en), .pin_in(pin_in));

    // 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Bus cycles: one-cycle strobes, read data only in the next cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] ex);
        @(posedge clock);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        `CHK(nm, ex, rdata_q)
    endtask

    // Settle point away from the edge
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // Board pin change, held for many clocks so it is never too short
    task automatic pin(input int p, input int b, input logic v);
        @(posedge clock);
        ext_val[p][b] <= v;
    endtask

    task automatic t_reset();
        for (int p = 0; p < NPORT; p++) begin
            rd("in", IN_ADDR[p], 8'h00);
            rd("out", OUT_ADDR[p], 8'h00);
            rd("dir", DIR_ADDR[p], 8'h00);
            rd("sel", SEL_ADDR[p], 8'h00);
        end
        for (int p = 0; p < NIRQ; p++) begin
            rd("ifg", IFG_ADDR[p], 8'h00);
            rd("ies", IES_ADDR[p], 8'h00);
            rd("ie", IE_ADDR[p], 8'h00);
        end
        rd("unmapped", 8'h00, 8'h00);
        rd("mask", MASK_ADDR, 8'h00);
    endtask

    // Mixed directions on one port; input register is read-only
    task automatic t_io();
        @(posedge clock);
        ext_en[4] <= 8'h0F;
        ext_val[4] <= 8'h03;
        wr(DIR_ADDR[4], 8'hF0);
        wr(OUT_ADDR[4], 8'hA5);
        wr(IN_ADDR[4], 8'hFF);
        wait_cyc(4);
        `CHK("oe4", 8'hF0, pin_oe_q[4])
        `CHK("out4", 8'hA0, pin_out_q[4] & 8'hF0)
        rd("in4", IN_ADDR[4], 8'hA3);
        rd("out4r", OUT_ADDR[4], 8'hA5);
    endtask

    // Peripheral function: direction untouched, input latch holds after deselect
    task automatic t_sel();
        @(posedge clock);
        periph_out[2] <= 8'h3C;
        ext_en[2] <= 8'hF0;
        ext_val[2] <= 8'h90;
        periph_out[3] <= 8'h5A;
        wr(SEL_ADDR[2], 8'hFF);
        wr(SEL_ADDR[3], 8'hFF);
        wr(DIR_ADDR[2], 8'h0F);
        wait_cyc(6);
        rd("dir2", DIR_ADDR[2], 8'h0F);
        `CHK("oe2", 8'h0F, pin_oe_q[2])
        `CHK("pout2", 8'h0C, pin_out_q[2] & 8'h0F)
        `CHK("pin2", 8'h9C, periph_in_q[2])
        `CHK("pout3", 8'h5A, pin_out_q[3])
        `CHK("oe3", 8'h00, pin_oe_q[3])
        wr(SEL_ADDR[2], 8'h00);
        wr(OUT_ADDR[2], 8'h05);
        @(posedge clock);
        ext_val[2] <= 8'h60;
        wait_cyc(6);
        `CHK("hold2", 8'h9C, periph_in_q[2])
        `CHK("out2", 8'h05, pin_out_q[2] & 8'h0F)
        rd("in2", IN_ADDR[2], 8'h65);
    endtask

    // Edges, enables, global gate, status and edge-select flips on port 0
    task automatic t_irq();
        @(posedge clock);
        global_interrupt_enable <= 1'b1;
        ext_en[0] <= 8'h01;
        wr(IE_ADDR[0], 8'h01);
        wr(MASK_ADDR, 8'h01);
        wait_cyc(6);
        rd("static", IFG_ADDR[0], 8'h00);
        pin(0, 0, 1'b1);
        wait_cyc(6);
        `CHK("irq0", 2'b01, port_irq_q)
        `CHK("irqs", 1'b1, irq_q)
        rd("stat", STAT_ADDR, 8'h01);
        rd("stat_clr", STAT_ADDR, 8'h00);
        wait_cyc(2);
        `CHK("irqs_clr", 1'b0, irq_q)
        rd("sticky", IFG_ADDR[0], 8'h01);
        wr(IFG_ADDR[0], 8'h00);
        wait_cyc(3);
        `CHK("cleared", 2'b00, port_irq_q)
        wr(IES_ADDR[0], 8'h01);
        @(posedge clock);
        global_interrupt_enable <= 1'b0;
        pin(0, 0, 1'b0);
        wait_cyc(6);
        `CHK("glob_off", 2'b00, port_irq_q)
        rd("fall", IFG_ADDR[0], 8'h01);
        @(posedge clock);
        global_interrupt_enable <= 1'b1;
        wait_cyc(3);
        `CHK("glob_on", 2'b01, port_irq_q)
        wr(IE_ADDR[0], 8'h00);
        wait_cyc(3);
        `CHK("ie_off", 2'b00, port_irq_q)
        wr(IFG_ADDR[0], 8'h00);
        wr(IES_ADDR[0], 8'h00);
        wr(IES_ADDR[0], 8'h01);
        wait_cyc(2);
        rd("ies_flip", IFG_ADDR[0], 8'h01);
        wr(IFG_ADDR[0], 8'h00);
    endtask

    // Own output drive loops back and raises a rising-edge flag
    task automatic t_loop();
        wr(DIR_ADDR[0], 8'h08);
        wr(OUT_ADDR[0], 8'h08);
        wait_cyc(6);
        rd("loop", IFG_ADDR[0], 8'h08);
        wr(IFG_ADDR[0], 8'h00);
    endtask

    // Selected pin ignores edges; software set on the second port
    task automatic t_sel_irq();
        @(posedge clock);
        ext_en[1] <= 8'h04;
        wr(SEL_ADDR[1], 8'h04);
        wr(IE_ADDR[1], 8'h84);
        pin(1, 2, 1'b1);
        wait_cyc(6);
        rd("sel_edge", IFG_ADDR[1], 8'h00);
        `CHK("sel_irq", 2'b00, port_irq_q)
        wr(IFG_ADDR[1], 8'h80);
        wait_cyc(3);
        `CHK("sw_irq", 2'b10, port_irq_q)
        wr(SEL_ADDR[1], 8'h00);
        pin(1, 2, 1'b0);
        wait_cyc(4);
        pin(1, 2, 1'b1);
        wait_cyc(6);
        rd("p1_edge", IFG_ADDR[1], 8'h84);
        rd("stat_both", STAT_ADDR, 8'h03);
    endtask

    initial begin
        rstn = 1'b0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        global_interrupt_enable = 1'b0;
        periph_out = '0;
        ext_val = '0;
        ext_en = '0;
        repeat (3) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_io();
        t_sel();
        t_irq();
        t_loop();
        t_sel_irq();
        wrap_up();
    end
endmodule
`default_nettype wire
